// >>> adc_result_compare_config.sv
// Result, compare and configuration registers of the converter.
// Assumes the core delivers a one-cycle done pulse with a 12-bit result on
// clk, and the alternate and internal clocks arrive as raw pin levels.
//
// Function
// (RULE_01) High register holds four or two top bits
// (RULE_02) Clear bits 11:10 or 11:8 per mode
// (RULE_03) Update results unless compare enabled and fails
// (RULE_04) Compare hit stores result minus compare value
// (RULE_05) High read locks results until low read
// (RULE_06) Results completing while locked are dropped
// (RULE_07) No interlock in 8-bit mode
// (RULE_08) Software discards results after mode change
// (RULE_09) Low register holds lower eight bits
// (RULE_10) 12-bit compare uses four high compare bits
// (RULE_11) 10-bit compare uses compare bits 9:8
// (RULE_12) 8-bit compare ignores high compare register
// (RULE_13) Low compare byte compared every conversion
// (RULE_14) Config bit 7 selects low power
// (RULE_15) Config 6:5 divides clock by 1,2,4,8
// (RULE_16) Config bit 4 selects long sample
// (RULE_17) Config 3:2 selects resolution
// (RULE_18) Config 1:0 selects input clock source
// (RULE_19) Pin bit n governs channel n pin
// (RULE_20) Set pin bit: no output, input, pullup
// (RULE_21) Compare less-than or greater-or-equal by select
module adc_result_compare_config
    import adc_result_pkg::*;
#(
    parameter int CHANNELS = 8  // Channels covered by the pin register.
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [2:0]          regAddr,
    input  wire logic [7:0]          regWriteData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output      logic [7:0]          regReadData,
    input  wire logic                convDone,
    input  wire logic [11:0]         convResult,
    input  wire logic                alternateClockPin,
    input  wire logic                internalAsyncClockPin,
    output      logic                converterClockTick,
    output      logic                lowPowerMode,
    output      logic                longSample,
    output      logic [1:0]          convMode,
    output      logic                compareHit,
    output      logic [CHANNELS-1:0] portOutputDisable,
    output      logic [CHANNELS-1:0] portInputDisable,
    output      logic [CHANNELS-1:0] pullupDisable
);
    import adc_result_pkg::*;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0]          resultHigh;     // Result, upper bits.
    logic [7:0]          resultLow;      // Result, lower byte.
    logic [7:0]          compareHigh;    // Compare value, upper bits.
    logic [7:0]          compareLow;     // Compare value, lower byte.
    logic [7:0]          configuration;  // Converter configuration.
    logic [CHANNELS-1:0] pinSelect;      // Analog pin select.
    logic                compareEnable;  // Compare function enable.
    logic                compareGreater; // Greater-or-equal select.
    lock_t               lockState;      // Read interlock state.

    // ****************************************************************
    // Compare datapath.
    // ****************************************************************
    logic [1:0]  mode;        // Current resolution code.
    logic [3:0]  highMask;    // Upper nibble kept in this mode.
    logic [11:0] maskedRes;   // Result with unused bits cleared.
    logic [11:0] maskedCmp;   // Compare value with unused bits cleared.
    logic        isLess;      // Result below compare value.
    logic        cmpTrue;     // Compare condition satisfied.
    logic [11:0] difference;  // Result plus two's complement of compare.
    logic        takeResult;  // Conversion will be written.

    assign mode = configuration[CFG_MODE_HI:CFG_MODE_LO];

    // Pick which upper bits live in this mode; reserved mode keeps all.
    always_comb begin
        if (mode == MODE_8) begin
            highMask = MASK_8;                           // [RULE_02]
        end else if (mode == MODE_10) begin
            highMask = MASK_10;                          // [RULE_02]
        end else begin
            highMask = MASK_12;                          // [RULE_01]
        end
    end

    // The compare value is masked the same way, so 8-bit mode never looks
    // at the high compare register and 10-bit mode uses only bits 9:8.
    assign maskedRes  = {convResult[11:8] & highMask, convResult[7:0]};
    assign maskedCmp  = {compareHigh[3:0] & highMask,
                         compareLow};                    // [RULE_10] [RULE_11] [RULE_12] [RULE_13]
    assign isLess     = maskedRes < maskedCmp;
    assign cmpTrue    = compareGreater ? !isLess : isLess; // [RULE_21]
    assign difference = maskedRes + ((~maskedCmp) + 12'h001); // [RULE_04]

    // A result is kept if compare passes and, outside 8-bit mode, no lock holds or starts now.
    // Outside 8-bit mode a high read in the same cycle blocks it too, so the pair stays whole.
    assign takeResult = convDone && (!compareEnable || cmpTrue) // [RULE_03]
        && (mode == MODE_8                                      // [RULE_07]
            || (lockState == OPEN && !(regRead
            && regAddr == OFS_RESULT_HIGH)));          // [RULE_05] [RULE_06]

    // ****************************************************************
    // Result registers.
    // ****************************************************************
    // Upper bits beyond the mode are masked again so subtraction borrow
    // cannot leak into bits that must read as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultHigh <= RESET_BYTE;
            resultLow  <= RESET_BYTE;
        end else if (takeResult) begin
            if (compareEnable) begin
                resultHigh <= {4'h0, difference[11:8] & highMask}; // [RULE_04]
                resultLow  <= difference[7:0];
            end else begin
                resultHigh <= {4'h0, maskedRes[11:8]};   // [RULE_01] [RULE_02]
                resultLow  <= maskedRes[7:0];            // [RULE_09]
            end
        end
    end

    // Compare hit pulse follows every written compare result.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compareHit <= 1'b0;
        end else begin
            compareHit <= takeResult && compareEnable;
        end
    end

    // ****************************************************************
    // Read interlock.
    // ****************************************************************
    // A high read locks outside 8-bit mode; a low read releases. A low read wins if both
    // arrive, which cannot happen since strobes are one at a time. Any
    // conversion during the lock outside 8-bit mode is simply not stored, never queued.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lockState <= OPEN;
        end else if (regRead && regAddr == OFS_RESULT_LOW) begin
            lockState <= OPEN;                           // [RULE_05]
        end else if (regRead && regAddr == OFS_RESULT_HIGH
                     && mode != MODE_8) begin
            lockState <= LOCKED;                         // [RULE_05] [RULE_07]
        end
    end

    // ****************************************************************
    // Register writes.
    // ****************************************************************
    // Software must ignore old results after a mode change; the block
    // does not clear them.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compareHigh    <= RESET_BYTE;
            compareLow     <= RESET_BYTE;
            configuration  <= RESET_BYTE;
            pinSelect      <= '0;
            compareEnable  <= 1'b0;
            compareGreater <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == OFS_CMP_HIGH) begin
                compareHigh <= regWriteData;
            end else if (regAddr == OFS_CMP_LOW) begin
                compareLow <= regWriteData;
            end else if (regAddr == OFS_CONFIG) begin
                configuration <= regWriteData;           // [RULE_08]
            end else if (regAddr == OFS_PIN_LOW) begin
                pinSelect <= regWriteData[CHANNELS-1:0]; // [RULE_19]
            end else if (regAddr == OFS_CMP_CTRL) begin
                compareEnable  <= regWriteData[CMPC_EN_BIT];
                compareGreater <= regWriteData[CMPC_GT_BIT];
            end
        end
    end

    // ****************************************************************
    // Register reads.
    // ****************************************************************
    // Data stand one cycle after the strobe and read zero otherwise.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regReadData <= RESET_BYTE;
        end else if (!regRead) begin
            regReadData <= RESET_BYTE;
        end else if (regAddr == OFS_RESULT_HIGH) begin
            regReadData <= resultHigh;
        end else if (regAddr == OFS_RESULT_LOW) begin
            regReadData <= resultLow;
        end else if (regAddr == OFS_CMP_HIGH) begin
            regReadData <= compareHigh;
        end else if (regAddr == OFS_CMP_LOW) begin
            regReadData <= compareLow;
        end else if (regAddr == OFS_CONFIG) begin
            regReadData <= configuration;
        end else if (regAddr == OFS_PIN_LOW) begin
            regReadData <= 8'(pinSelect);
        end else if (regAddr == OFS_CMP_CTRL) begin
            regReadData <= {6'h00, compareGreater, compareEnable};
        end else begin
            regReadData <= RESET_BYTE;
        end
    end

    // ****************************************************************
    // Configuration outputs and pin control.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowPowerMode      <= 1'b0;
            longSample        <= 1'b0;
            convMode          <= MODE_8;
            portOutputDisable <= '0;
            portInputDisable  <= '0;
            pullupDisable     <= '0;
        end else begin
            lowPowerMode      <= configuration[CFG_LOWPWR_BIT]; // [RULE_14]
            longSample        <= configuration[CFG_LSMP_BIT];   // [RULE_16]
            convMode          <= mode;                          // [RULE_17]
            portOutputDisable <= pinSelect;                     // [RULE_20]
            portInputDisable  <= pinSelect;                     // [RULE_20]
            pullupDisable     <= pinSelect;                     // [RULE_20]
        end
    end

    // ****************************************************************
    // Clock source selection and divider.
    // ****************************************************************
    // External clocks are only sampled here, so they must be well under
    // half the bus rate; the tick is an enable, not a real clock.
    logic [1:0] altSync;     // Alternate clock synchroniser.
    logic [1:0] asyncSync;   // Internal clock synchroniser.
    logic       altLast;     // Previous synchronised alternate level.
    logic       asyncLast;   // Previous synchronised internal level.
    logic       halfToggle;  // Bus clock halved.
    logic       srcTick;     // One pulse per selected source edge.
    logic [2:0] divCount;    // Divider counter.
    logic [2:0] divLimit;    // Terminal count for the divider.

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            altSync    <= 2'h0;
            asyncSync  <= 2'h0;
            altLast    <= 1'b0;
            asyncLast  <= 1'b0;
            halfToggle <= 1'b0;
        end else begin
            altSync    <= {altSync[0], alternateClockPin};
            asyncSync  <= {asyncSync[0], internalAsyncClockPin};
            altLast    <= altSync[1];
            asyncLast  <= asyncSync[1];
            halfToggle <= !halfToggle;
        end
    end

    // Source selection.
    always_comb begin
        if (configuration[CFG_CLK_HI:CFG_CLK_LO] == SRC_BUS) begin
            srcTick = 1'b1;                              // [RULE_18]
        end else if (configuration[CFG_CLK_HI:CFG_CLK_LO] == SRC_BUS2) begin
            srcTick = halfToggle;                        // [RULE_18]
        end else if (configuration[CFG_CLK_HI:CFG_CLK_LO] == SRC_ALT) begin
            srcTick = altSync[1] && !altLast;            // [RULE_18]
        end else begin
            srcTick = asyncSync[1] && !asyncLast;        // [RULE_18]
        end
    end

    // Divide ratio 1, 2, 4 or 8 as a terminal count.
    assign divLimit = 3'((4'h1 << configuration[CFG_DIV_HI:CFG_DIV_LO])
                         - 4'h1);                        // [RULE_15]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCount           <= 3'h0;
            converterClockTick <= 1'b0;
        end else if (srcTick) begin
            if (divCount >= divLimit) begin
                divCount           <= 3'h0;
                converterClockTick <= 1'b1;              // [RULE_15]
            end else begin
                divCount           <= divCount + 3'h1;
                converterClockTick <= 1'b0;
            end
        end else begin
            converterClockTick <= 1'b0;
        end
    end

endmodule // adc_result_compare_config

// >>> adc_result_pkg.sv
// Package for the converter result, compare and configuration block.
// Assumes a single 20 MHz clock and a plain register port in the host.
package adc_result_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h0; // Result, upper bits.
    localparam logic [2:0] OFS_RESULT_LOW  = 3'h1; // Result, lower byte.
    localparam logic [2:0] OFS_CMP_HIGH    = 3'h2; // Compare, upper bits.
    localparam logic [2:0] OFS_CMP_LOW     = 3'h3; // Compare, lower byte.
    localparam logic [2:0] OFS_CONFIG      = 3'h4; // Configuration.
    localparam logic [2:0] OFS_PIN_LOW     = 3'h5; // Pin control 0..7.
    localparam logic [2:0] OFS_CMP_CTRL    = 3'h6; // Compare enable/select.

    // ****************************************************************
    // Configuration fields.
    // ****************************************************************
    localparam int CFG_LOWPWR_BIT = 7;  // Low power select.
    localparam int CFG_DIV_HI     = 6;  // Clock divide field, top.
    localparam int CFG_DIV_LO     = 5;  // Clock divide field, bottom.
    localparam int CFG_LSMP_BIT   = 4;  // Long sample select.
    localparam int CFG_MODE_HI    = 3;  // Mode field, top.
    localparam int CFG_MODE_LO    = 2;  // Mode field, bottom.
    localparam int CFG_CLK_HI     = 1;  // Input clock field, top.
    localparam int CFG_CLK_LO     = 0;  // Input clock field, bottom.
    localparam int CMPC_EN_BIT    = 0;  // Compare enable bit.
    localparam int CMPC_GT_BIT    = 1;  // Greater-or-equal select bit.

    localparam logic [7:0] RESET_BYTE = 8'h00; // Reset of every register.
    localparam logic [3:0] MASK_12    = 4'hF;  // Upper nibble, 12 bit.
    localparam logic [3:0] MASK_10    = 4'h3;  // Upper nibble, 10 bit.
    localparam logic [3:0] MASK_8     = 4'h0;  // Upper nibble, 8 bit.

    // Resolution codes.
    localparam logic [1:0] MODE_8  = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;

    // Input clock source codes.
    localparam logic [1:0] SRC_BUS   = 2'h0;
    localparam logic [1:0] SRC_BUS2  = 2'h1;
    localparam logic [1:0] SRC_ALT   = 2'h2;
    localparam logic [1:0] SRC_ASYNC = 2'h3;

    // Interlock states.
    typedef enum logic {
        OPEN,
        LOCKED
    } lock_t;

endpackage : adc_result_pkg

// >>> adc_result_compare_config_props.sv
// Checker for the converter result, compare and configuration block.
// Assumes it is bound into the top module and sees only its ports.
module adc_result_compare_config_props
    import adc_result_pkg::*;
#(
    parameter int CHANNELS = 8  // Width of the pin control outputs.
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [2:0]          regAddr,
    input wire logic [7:0]          regWriteData,
    input wire logic                regWrite,
    input wire logic                regRead,
    input wire logic [7:0]          regReadData,
    input wire logic                convDone,
    input wire logic [11:0]         convResult,
    input wire logic                converterClockTick,
    input wire logic                lowPowerMode,
    input wire logic                longSample,
    input wire logic [1:0]          convMode,
    input wire logic                compareHit,
    input wire logic [CHANNELS-1:0] portOutputDisable,
    input wire logic [CHANNELS-1:0] portInputDisable,
    input wire logic [CHANNELS-1:0] pullupDisable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Shadow state rebuilt from the register and conversion ports.
    // ****************************************************************
    logic [7:0] cfgShadow; // Last configuration byte written.
    logic       cmpOn;     // Compare enable as last written.
    logic [1:0] stableCnt; // Cycles since the configuration changed.
    logic [7:0] rawLow;    // Low byte of the newest raw result.
    logic       cfgWr;     // Configuration write in this cycle.
    assign cfgWr = regWrite && regAddr == OFS_CONFIG;

    // The count keeps the tick check off the cycles where it settles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgShadow <= RESET_BYTE;
            cmpOn     <= 1'b0;
            stableCnt <= 2'd0;
            rawLow    <= RESET_BYTE;
        end else begin
            if (cfgWr) begin
                cfgShadow <= regWriteData;
                stableCnt <= 2'd0;
            end else if (stableCnt != 2'd3) begin
                stableCnt <= stableCnt + 2'd1;
            end
            if (regWrite && regAddr == OFS_CMP_CTRL) begin
                cmpOn <= regWriteData[CMPC_EN_BIT];
            end
            if (convDone) begin
                rawLow <= convResult[7:0];
            end
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    // Outputs copy their registers one edge after the write lands, so a
    // write shows at the second edge after its strobe.
    a_mode_follows: assert property (
        cfgWr |-> ##2
            convMode == $past(regWriteData[CFG_MODE_HI:CFG_MODE_LO], 2))
        else $error("mode output differs from the written field");
    a_power_sample: assert property (
        cfgWr |-> ##2 {lowPowerMode, longSample} ==
            $past({regWriteData[7], regWriteData[4]}, 2))
        else $error("power or sample output differs from written bits");
    a_mode_hold: assert property (
        !cfgWr |-> ##2 $stable(convMode))
        else $error("mode output moved without a write");
    a_pin_follows: assert property (
        regWrite && regAddr == OFS_PIN_LOW |-> ##2
            portOutputDisable == $past(regWriteData[CHANNELS-1:0], 2))
        else $error("pin control output differs from written byte");
    a_pins_agree: assert property (
        portInputDisable == portOutputDisable &&
        pullupDisable == portOutputDisable)
        else $error("pin disable outputs disagree");
    a_hit_cause: assert property (
        compareHit |-> $past(convDone))
        else $error("compare hit without a conversion");
    a_tick_full: assert property (
        stableCnt == 2'd3 && cfgShadow[6:5] == 2'b00 &&
        cfgShadow[1:0] == SRC_BUS |-> converterClockTick)
        else $error("undivided bus clock gave no tick");
    a_low_raw8: assert property (
        regRead && regAddr == OFS_RESULT_LOW && convMode == MODE_8 &&
        !cmpOn && !convDone |=> regReadData == rawLow)
        else $error("8-bit low result differs from raw result");

    c_hit: cover property (compareHit);
    c_mode10: cover property (cfgWr ##1 convMode == MODE_10);
    c_read12: cover property (convDone && convMode == MODE_12 ##[1:8] regRead);
endmodule // adc_result_compare_config_props

// >>> adc_result_compare_config_tb.sv
// Self-checking bench for the converter result and configuration block.
// Assumes the package, design and checker files are compiled first.
module adc_result_compare_config_tb
    import adc_result_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Stimulus, responses and counters.
    // ****************************************************************
    logic       clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic       convDone = 1'b0, altPin = 1'b0, asyncPin = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWriteData = 8'h00, regReadData, d, ticks;
    logic [11:0] convResult = 12'h000;
    logic       converterClockTick, lowPowerMode, longSample, compareHit;
    logic [1:0] convMode;
    logic [7:0] outDis, inDis, pullDis;
    logic       hit;
    int         mismatches = 0, checks_done = 0, edgeCnt = 0;
    // One row: mode, compare control and values, raw result, expectations.
    typedef struct packed {
        logic [7:0] cfg, ctrl, cvh, cvl;
        logic [11:0] res;
        logic [7:0] hi, lo;
        logic       hit;
    } row_t;
    row_t rows [9] = '{
        '{8'h04, 8'h00, 8'h00, 8'h00, 12'hABC, 8'h0A, 8'hBC, 1'b0},
        '{8'h08, 8'h00, 8'h00, 8'h00, 12'hABC, 8'h02, 8'hBC, 1'b0},
        '{8'h00, 8'h00, 8'h00, 8'h00, 12'hABC, 8'h00, 8'hBC, 1'b0},
        '{8'h04, 8'h03, 8'h0A, 8'h00, 12'hB3C, 8'h01, 8'h3C, 1'b1},
        '{8'h04, 8'h03, 8'h0A, 8'h00, 12'h9FF, 8'h01, 8'h3C, 1'b0},
        '{8'h04, 8'h01, 8'h0A, 8'h00, 12'h9FF, 8'h0F, 8'hFF, 1'b1},
        '{8'h08, 8'h03, 8'h0F, 8'h10, 12'hF20, 8'h00, 8'h10, 1'b1},
        '{8'h00, 8'h03, 8'h0F, 8'h80, 12'h0A5, 8'h00, 8'h25, 1'b1},
        '{8'h00, 8'h03, 8'h0F, 8'h80, 12'h07F, 8'h00, 8'h25, 1'b0}
    };
    // Clock source and divider settings with ticks expected in 80 cycles.
    logic [7:0] divCfg [8] = '{8'h00, 8'h20, 8'h40, 8'h60,
                               8'h01, 8'h61, 8'h02, 8'h03};
    logic [7:0] divExp [8] = '{8'h50, 8'h28, 8'h14, 8'h0A,
                               8'h28, 8'h05, 8'h0A, 8'h08};

    adc_result_compare_config i_dut (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .convDone(convDone),
        .convResult(convResult), .alternateClockPin(altPin),
        .internalAsyncClockPin(asyncPin),
        .converterClockTick(converterClockTick),
        .lowPowerMode(lowPowerMode), .longSample(longSample),
        .convMode(convMode), .compareHit(compareHit),
        .portOutputDisable(outDis), .portInputDisable(inDis),
        .pullupDisable(pullDis)
    );

    // The 50 ns clock.
    initial begin
        forever #25 clk = ~clk;
    end

    // Alternate clock of 8 cycles, internal clock of 10, both from counts.
    always @(posedge clk) begin
        edgeCnt <= edgeCnt + 1;
        altPin <= (edgeCnt % 8) >= 4;
        asyncPin <= (edgeCnt % 10) >= 5;
    end

    // ****************************************************************
    // Bus, conversion and compare tasks.
    // ****************************************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regReadData;
    endtask
    // The hit flag is sampled in the cycle after the done pulse.
    task automatic conv(input logic [11:0] r, output logic h);
        @(posedge clk);
        convDone <= 1'b1;
        convResult <= r;
        @(posedge clk);
        convDone <= 1'b0;
        #1 h = compareHit;
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and goes to the report.
    initial begin
        #5000000;
        mismatches++;
        final_report();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            check8(d, RESET_BYTE); // Reset values, and zero when unmapped.
        end
        // Mode is rewritten before each conversion that it governs.
        foreach (rows[i]) begin
            wr(OFS_CONFIG, rows[i].cfg);
            wr(OFS_CMP_HIGH, rows[i].cvh);
            wr(OFS_CMP_LOW, rows[i].cvl);
            wr(OFS_CMP_CTRL, rows[i].ctrl);
            conv(rows[i].res, hit);
            check8({7'h00, hit}, {7'h00, rows[i].hit});
            rd(OFS_RESULT_HIGH, d);
            check8(d, rows[i].hi);
            rd(OFS_RESULT_LOW, d);
            check8(d, rows[i].lo);
        end
        wr(OFS_CMP_CTRL, 8'h00);
        // A high read locks out later results until the low read.
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CONFIG, (m == 0) ? 8'h04 : 8'h08);
            conv(12'h123, hit);
            rd(OFS_RESULT_HIGH, d);
            check8(d, 8'h01);
            conv(12'h456, hit);
            rd(OFS_RESULT_LOW, d);
            check8(d, 8'h23);
            conv(12'h389, hit);
            rd(OFS_RESULT_LOW, d);
            check8(d, 8'h89);
        end
        wr(OFS_CONFIG, 8'h00);
        conv(12'h011, hit);
        rd(OFS_RESULT_HIGH, d);
        conv(12'h022, hit);
        rd(OFS_RESULT_LOW, d);
        check8(d, 8'h22);
        wr(OFS_RESULT_LOW, 8'hFF);
        rd(OFS_RESULT_LOW, d);
        check8(d, 8'h22);
        wr(OFS_CONFIG, 8'h94);
        @(posedge clk);
        #1;
        check8({4'h0, lowPowerMode, longSample, convMode}, 8'h0D);
        rd(OFS_CONFIG, d);
        check8(d, 8'h94);
        wr(OFS_CONFIG, 8'h0C);
        @(posedge clk);
        #1;
        check8({6'h00, convMode}, 8'h03);
        for (int n = 0; n < 8; n++) begin
            wr(OFS_PIN_LOW, 8'h01 << n);
            @(posedge clk);
            #1;
            check8(outDis, 8'h01 << n);
            check8(inDis, 8'h01 << n);
            check8(pullDis, 8'h01 << n);
        end
        foreach (divCfg[k]) begin
            wr(OFS_CONFIG, divCfg[k]);
            repeat (20) @(posedge clk);
            ticks = 8'h00;
            repeat (80) begin
                @(posedge clk);
                #1 ticks += {7'h00, converterClockTick};
            end
            check8(ticks, divExp[k]);
        end
        // A reset in mid-run must clear used registers again.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CONFIG, d);
        check8(d, RESET_BYTE);
        rd(OFS_RESULT_LOW, d);
        check8(d, RESET_BYTE);
        final_report();
    end
endmodule // adc_result_compare_config_tb

bind adc_result_compare_config adc_result_compare_config_props #(
    .CHANNELS(CHANNELS)
) i_props (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .convDone(convDone),
    .convResult(convResult), .converterClockTick(converterClockTick),
    .lowPowerMode(lowPowerMode), .longSample(longSample),
    .convMode(convMode), .compareHit(compareHit),
    .portOutputDisable(portOutputDisable),
    .portInputDisable(portInputDisable), .pullupDisable(pullupDisable)
);
